/* hdl/status_word_transfer.sv */
//
// Behaviour
// - status read copies current or saved status word into destination register.
// - saved-word read in user or system mode is undefined; flagged, no register or status word written.
// - instruction bit 22 selects current (0) or saved (1) status word.
// - bit 25 high takes rotated immediate, else register in low four bits.
// - immediate operand is 8-bit value rotated right by twice rotate field.
// - lane field bits 16 to 19 select control, extension, status, flags.
// - each set lane bit n gives all-ones byte n in byte mask.
// - operand hitting unassigned bits is unpredictable; flagged, no defined result.
// - newest version uses its four permission mask constants.
// - dsp fifth version uses its four permission mask constants.
// - privileged current write: isa bits unpredictable, else unpriv or super mask.
// - user-mode current write limited to unprivileged writable bits.
// - masked bits take operand, all other bits keep old value.
// - saved write mask includes unpriv, super and isa bits; needs saved word.
// - saved write in user or system mode is unpredictable; no update made.
// - legacy names encode lanes as 1001, 1000 and 0001.
// - only immediate and unshifted register operand forms are valid.
//
module status_word_transfer
   import status_xfer_pkg::*;
(
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic instr_valid_in,
   input wire logic [31:0] instr_in,
   input wire logic [31:0] source_gpr_in,
   input wire arch_ver_t arch_ver_in,
   output logic [3:0] source_index_out,
   output gpr_write_t gpr_write_out,
   output logic [31:0] current_status_word_out,
   output logic [31:0] saved_status_word_out,
   output logic unpredictable_out
);

   // ----------------------------------------------------------------
   // architectural state
   // ----------------------------------------------------------------
   logic [31:0] current_status_word;
   logic [31:0] saved_status_word;
   logic [3:0] source_index;
   gpr_write_t gpr_write;
   logic unpredictable;

   // ----------------------------------------------------------------
   // field extraction
   // ----------------------------------------------------------------
   wire [3:0] cond_field = instr_in[COND_HI:COND_LO];
   wire imm_form = instr_in[IMM_SEL_BIT];
   wire target_saved = instr_in[TARGET_SEL_BIT];
   wire [3:0] lane_field = instr_in[LANE_HI:LANE_LO];
   wire [3:0] dest_index = instr_in[DEST_HI:DEST_LO];
   wire [3:0] rot_field = instr_in[ROT_HI:ROT_LO];
   wire [7:0] imm8 = instr_in[IMM8_HI:IMM8_LO];

   // ----------------------------------------------------------------
   // decode and mode
   // ----------------------------------------------------------------
   wire is_read = ((instr_in & READ_MATCH_MASK) == READ_MATCH_VAL);
   wire is_write = ((instr_in & WRITE_MATCH_MASK) == WRITE_MATCH_VAL);
   wire [4:0] mode = current_status_word[4:0];
   wire in_user = (mode == MODE_USER);
   wire has_saved = !in_user && (mode != MODE_SYSTEM);
   flags_t cur_flags;
   assign cur_flags = flags_t'(current_status_word[31:28]);

   logic cond_pass;
   cond_check cond_unit
   (
      .cond_in(cond_field),
      .flags_in(cur_flags),
      .pass_out(cond_pass)
   );

   wire go = instr_valid_in && cond_pass;
   wire read_go = go && is_read;
   wire write_go = go && is_write;

   // ----------------------------------------------------------------
   // operand formation
   // ----------------------------------------------------------------
   wire [4:0] rot_amt = {rot_field, 1'b0};
   wire [63:0] imm_dbl = {24'h000000, imm8, 24'h000000, imm8};
   wire [63:0] imm_shift = imm_dbl >> rot_amt;
   wire [31:0] imm_operand = imm_shift[31:0];
   wire [31:0] operand = imm_form ? imm_operand : source_gpr_in;
   wire bad_form = !imm_form && ((instr_in[IMM8_HI:IMM8_LO] & REG_FORM_ZERO_MASK) != 8'h00);

   // ----------------------------------------------------------------
   // permission mask selection by version
   // ----------------------------------------------------------------
   perm_masks_t masks;
   assign masks = (arch_ver_in == VER_NEWEST) ?
      perm_masks_t'({V6_UNASSIGNED, V6_UNPRIV, V6_SUPER, V6_EXEC_ISA}) :
      perm_masks_t'({V5_UNASSIGNED, V5_UNPRIV, V5_SUPER, V5_EXEC_ISA});

   // ----------------------------------------------------------------
   // byte mask expansion, one lane per byte
   // ----------------------------------------------------------------
   logic [31:0] byte_mask;
   genvar lane;
   generate
      for (lane = 0; lane < 4; lane++)
      begin : g_lane
         assign byte_mask[lane*8 +: 8] = {8{lane_field[lane]}};
      end
   endgenerate

   // ----------------------------------------------------------------
   // effective masks and unpredictable cases
   // ----------------------------------------------------------------
   wire hits_unassigned = |(operand & masks.unassigned_bits_pattern);
   wire hits_isa = |(operand & masks.exec_isa_bits);
   wire [31:0] cur_mask_priv = byte_mask & (masks.unprivileged_writable_bits
      | masks.supervisor_writable_bits);
   wire [31:0] cur_mask_user = byte_mask & masks.unprivileged_writable_bits;
   wire [31:0] cur_mask = in_user ? cur_mask_user : cur_mask_priv;
   wire [31:0] saved_mask = byte_mask & (masks.unprivileged_writable_bits
      | masks.supervisor_writable_bits | masks.exec_isa_bits);
   wire priv_isa_bad = !target_saved && !in_user && hits_isa;
   wire saved_bad = target_saved && !has_saved;
   wire read_bad = instr_in[TARGET_SEL_BIT] && !has_saved;
   wire write_bad = hits_unassigned || priv_isa_bad || saved_bad || bad_form;

   // ----------------------------------------------------------------
   // next status words: masked merge
   // ----------------------------------------------------------------
   wire cur_wr = write_go && !target_saved && !write_bad;
   wire sav_wr = write_go && target_saved && !write_bad;
   wire [31:0] next_current = cur_wr ?
      ((current_status_word & ~cur_mask) | (operand & cur_mask)) : current_status_word;
   wire [31:0] next_saved = sav_wr ?
      ((saved_status_word & ~saved_mask) | (operand & saved_mask)) : saved_status_word;

   // ----------------------------------------------------------------
   // register file write for the read instruction
   // ----------------------------------------------------------------
   wire read_ok = read_go && !read_bad;
   wire [31:0] read_value = instr_in[TARGET_SEL_BIT] ? saved_status_word : current_status_word;
   gpr_write_t next_gpr_write;
   assign next_gpr_write = '{valid: read_ok, index: dest_index, data: read_value};
   wire next_unpredictable = (read_go && read_bad) || (write_go && write_bad);

   // ----------------------------------------------------------------
   // state update
   // ----------------------------------------------------------------
   always_ff @(posedge clk_in)
   begin
      if (reset_in)
      begin
         current_status_word <= STATUS_RESET;
         saved_status_word <= SAVED_RESET;
         gpr_write <= '0;
         unpredictable <= 1'b0;
         source_index <= 4'h0;
      end
      else
      begin
         current_status_word <= next_current;
         saved_status_word <= next_saved;
         gpr_write <= next_gpr_write;
         unpredictable <= next_unpredictable;
         source_index <= instr_in[SRC_HI:SRC_LO];
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign current_status_word_out = current_status_word;
   assign saved_status_word_out = saved_status_word;
   assign gpr_write_out = gpr_write;
   assign unpredictable_out = unpredictable;
   assign source_index_out = source_index;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   AST_READ_COPY: assert property (@(posedge clk_in) disable iff (reset_in)
      read_ok |=> gpr_write.valid && gpr_write.data == $past(read_value))
      else $error("status read value wrong");

   AST_READ_BAD_QUIET: assert property (@(posedge clk_in) disable iff (reset_in)
      (read_go && read_bad) |=> !gpr_write.valid && unpredictable)
      else $error("bad saved read wrote register");

   AST_TARGET_CURRENT: assert property (@(posedge clk_in) disable iff (reset_in)
      (write_go && !target_saved) |=> $stable(saved_status_word))
      else $error("current write touched saved word");

   AST_IMM_OPERAND: assert property (@(posedge clk_in) disable iff (reset_in)
      (cur_wr && imm_form && lane_field == 4'h8)
      |=> current_status_word[31:27] == $past(imm_operand[31:27]))
      else $error("immediate flags not written");

   AST_BYTE_MASK: assert property (@(posedge clk_in) disable iff (reset_in)
      (cur_wr && !lane_field[0]) |=> current_status_word[7:0] == $past(current_status_word[7:0]))
      else $error("unselected control lane changed");

   AST_UNASSIGNED: assert property (@(posedge clk_in) disable iff (reset_in)
      (write_go && hits_unassigned) |=> unpredictable && $stable(current_status_word))
      else $error("unassigned write took effect");

   AST_USER_LIMIT: assert property (@(posedge clk_in) disable iff (reset_in)
      (write_go && !target_saved && in_user)
      |=> (current_status_word & ~$past(masks.unprivileged_writable_bits))
      == ($past(current_status_word) & ~$past(masks.unprivileged_writable_bits)))
      else $error("user write changed privileged bits");

   AST_SAVED_BAD: assert property (@(posedge clk_in) disable iff (reset_in)
      (write_go && saved_bad) |=> $stable(saved_status_word) && unpredictable)
      else $error("saved write without saved word");

   AST_COND_FAIL: assert property (@(posedge clk_in) disable iff (reset_in)
      (instr_valid_in && !cond_pass) |=> !gpr_write.valid && $stable(current_status_word)
      && $stable(saved_status_word))
      else $error("failed condition changed state");

   // index of a read
   AST_READ_INDEX: assert property (@(posedge clk_in) disable iff (reset_in)
      read_ok |=> gpr_write.index == $past(dest_index))
      else $error("read index wrong");

   // saved word read
   AST_READ_SAVED: assert property (@(posedge clk_in) disable iff (reset_in)
      (read_ok && target_saved) |=> gpr_write.data == $past(saved_status_word))
      else $error("saved read wrong");

   // current word read
   AST_READ_CURRENT: assert property (@(posedge clk_in) disable iff (reset_in)
      (read_ok && !target_saved) |=> gpr_write.data == $past(current_status_word))
      else $error("current read wrong");

   // reads leave both words
   AST_READ_KEEPS: assert property (@(posedge clk_in) disable iff (reset_in)
      read_go |=> $stable(current_status_word) && $stable(saved_status_word))
      else $error("read changed a status word");

   // saved target spares current
   AST_TARGET_SAVED: assert property (@(posedge clk_in) disable iff (reset_in)
      (write_go && target_saved) |=> $stable(current_status_word))
      else $error("saved write touched current word");

   // register operand, current
   AST_REG_CURRENT: assert property (@(posedge clk_in) disable iff (reset_in)
      (cur_wr && !imm_form)
      |=> (current_status_word & $past(cur_mask)) == ($past(source_gpr_in) & $past(cur_mask)))
      else $error("register operand not in current");

   // register operand, saved
   AST_REG_SAVED: assert property (@(posedge clk_in) disable iff (reset_in)
      (sav_wr && !imm_form)
      |=> (saved_status_word & $past(saved_mask)) == ($past(source_gpr_in) & $past(saved_mask)))
      else $error("register operand not in saved");

   // even right rotation
   AST_ROTATE: assert property (@(posedge clk_in) disable iff (reset_in)
      (write_go && imm_form) |-> imm_operand == (({24'h000000, imm8} >> rot_amt)
      | ({24'h000000, imm8} << (6'd32 - {1'b0, rot_amt}))))
      else $error("immediate rotation wrong");

   // immediate into saved word
   AST_IMM_SAVED: assert property (@(posedge clk_in) disable iff (reset_in)
      (sav_wr && imm_form)
      |=> (saved_status_word & $past(saved_mask)) == ($past(imm_operand) & $past(saved_mask)))
      else $error("immediate not in saved word");

   // extension lane off
   AST_LANE_EXT: assert property (@(posedge clk_in) disable iff (reset_in)
      (cur_wr && !lane_field[1]) |=> current_status_word[15:8] == $past(current_status_word[15:8]))
      else $error("extension lane changed");

   // status lane off
   AST_LANE_STATUS: assert property (@(posedge clk_in) disable iff (reset_in)
      (cur_wr && !lane_field[2]) |=> current_status_word[23:16] == $past(current_status_word[23:16]))
      else $error("status lane changed");

   // flags lane off
   AST_LANE_FLAGS: assert property (@(posedge clk_in) disable iff (reset_in)
      (cur_wr && !lane_field[3]) |=> current_status_word[31:24] == $past(current_status_word[31:24]))
      else $error("flags lane changed");

   // saved control lane off
   AST_SAVED_LANE: assert property (@(posedge clk_in) disable iff (reset_in)
      (sav_wr && !lane_field[0]) |=> saved_status_word[7:0] == $past(saved_status_word[7:0]))
      else $error("saved control lane changed");

   // newest version bounds
   AST_V6_BOUNDS: assert property (@(posedge clk_in) disable iff (reset_in)
      (cur_wr && arch_ver_in == VER_NEWEST) |=> (current_status_word & ~(V6_UNPRIV | V6_SUPER))
      == ($past(current_status_word) & ~(V6_UNPRIV | V6_SUPER)))
      else $error("newest write beyond its masks");

   // fifth version bounds
   AST_V5_BOUNDS: assert property (@(posedge clk_in) disable iff (reset_in)
      (cur_wr && arch_ver_in == VER_DSP5) |=> (current_status_word & ~(V5_UNPRIV | V5_SUPER))
      == ($past(current_status_word) & ~(V5_UNPRIV | V5_SUPER)))
      else $error("fifth write beyond its masks");

   // newest saved bounds
   AST_V6_SAVED: assert property (@(posedge clk_in) disable iff (reset_in)
      (sav_wr && arch_ver_in == VER_NEWEST)
      |=> (saved_status_word & ~(V6_UNPRIV | V6_SUPER | V6_EXEC_ISA))
      == ($past(saved_status_word) & ~(V6_UNPRIV | V6_SUPER | V6_EXEC_ISA)))
      else $error("saved write beyond its masks");

   // isa bits in privileged write
   AST_PRIV_ISA: assert property (@(posedge clk_in) disable iff (reset_in)
      (write_go && priv_isa_bad) |=> unpredictable && $stable(current_status_word))
      else $error("isa write took effect");

   // unmasked current bits kept
   AST_MERGE_KEEP: assert property (@(posedge clk_in) disable iff (reset_in)
      cur_wr |=> (current_status_word & ~$past(cur_mask))
      == ($past(current_status_word) & ~$past(cur_mask)))
      else $error("unmasked current bit changed");

   // unmasked saved bits kept
   AST_MERGE_SAVED: assert property (@(posedge clk_in) disable iff (reset_in)
      sav_wr |=> (saved_status_word & ~$past(saved_mask))
      == ($past(saved_status_word) & ~$past(saved_mask)))
      else $error("unmasked saved bit changed");

   // legacy flags-only form
   AST_LEGACY_FLAGS: assert property (@(posedge clk_in) disable iff (reset_in)
      (cur_wr && lane_field == LANES_FLAGS) |=> current_status_word[23:0] == $past(current_status_word[23:0]))
      else $error("flags form changed low bytes");

   // legacy all form, flags and control lanes only
   AST_LEGACY_ALL: assert property (@(posedge clk_in) disable iff (reset_in)
      (cur_wr && lane_field == LANES_ALL) |=> current_status_word[23:8] == $past(current_status_word[23:8]))
      else $error("all form changed middle bytes");

   // legacy control-only form
   AST_LEGACY_CTRL: assert property (@(posedge clk_in) disable iff (reset_in)
      (cur_wr && lane_field == LANES_CTRL) |=> current_status_word[31:8] == $past(current_status_word[31:8]))
      else $error("control form changed high bytes");

   // shifted register forms refused
   AST_BAD_FORM: assert property (@(posedge clk_in) disable iff (reset_in)
      (write_go && bad_form)
      |=> unpredictable && $stable(current_status_word) && $stable(saved_status_word))
      else $error("bad operand form took effect");

   // idle cycles change nothing
   AST_IDLE_QUIET: assert property (@(posedge clk_in) disable iff (reset_in)
      !instr_valid_in |=> !gpr_write.valid && !unpredictable
      && $stable(current_status_word) && $stable(saved_status_word))
      else $error("idle cycle changed state");

endmodule // status_word_transfer

/* hdl/status_xfer_pkg.sv */
package status_xfer_pkg;

   // ----------------------------------------------------------------
   // instruction field positions
   // ----------------------------------------------------------------
   localparam int COND_HI = 31;
   localparam int COND_LO = 28;
   localparam int IMM_SEL_BIT = 25;
   localparam int TARGET_SEL_BIT = 22;
   localparam int WRITE_OP_BIT = 21;
   localparam int LANE_HI = 19;
   localparam int LANE_LO = 16;
   localparam int DEST_HI = 15;
   localparam int DEST_LO = 12;
   localparam int ROT_HI = 11;
   localparam int ROT_LO = 8;
   localparam int IMM8_HI = 7;
   localparam int IMM8_LO = 0;
   localparam int SRC_HI = 3;
   localparam int SRC_LO = 0;

   // ----------------------------------------------------------------
   // opcode matching: fixed bits of both instructions
   // ----------------------------------------------------------------
   localparam logic [31:0] READ_MATCH_MASK = 32'h0fb0_0000;
   localparam logic [31:0] READ_MATCH_VAL = 32'h0100_0000;
   localparam logic [31:0] WRITE_MATCH_MASK = 32'h0db0_0000;
   localparam logic [31:0] WRITE_MATCH_VAL = 32'h0120_0000;
   localparam logic [7:0] REG_FORM_ZERO_MASK = 8'hf0; // bits 7:4 of unshifted register form

   // ----------------------------------------------------------------
   // permission masks, newest version
   // ----------------------------------------------------------------
   localparam logic [31:0] V6_UNASSIGNED = 32'h06f0_fc00;
   localparam logic [31:0] V6_UNPRIV = 32'hf80f_0200;
   localparam logic [31:0] V6_SUPER = 32'h0000_01df;
   localparam logic [31:0] V6_EXEC_ISA = 32'h0100_0020;

   // ----------------------------------------------------------------
   // permission masks, dsp-extended fifth version
   // ----------------------------------------------------------------
   localparam logic [31:0] V5_UNASSIGNED = 32'h07ff_ff00;
   localparam logic [31:0] V5_UNPRIV = 32'hf800_0000;
   localparam logic [31:0] V5_SUPER = 32'h0000_000f;
   localparam logic [31:0] V5_EXEC_ISA = 32'h0000_0020;

   // ----------------------------------------------------------------
   // legacy lane encodings and modes
   // ----------------------------------------------------------------
   localparam logic [3:0] LANES_ALL = 4'h9;
   localparam logic [3:0] LANES_FLAGS = 4'h8;
   localparam logic [3:0] LANES_CTRL = 4'h1;
   localparam logic [4:0] MODE_USER = 5'h10;
   localparam logic [4:0] MODE_SYSTEM = 5'h1f;
   localparam logic [31:0] STATUS_RESET = 32'h0000_00d3;
   localparam logic [31:0] SAVED_RESET = 32'h0000_0000;

   typedef enum logic {VER_DSP5, VER_NEWEST} arch_ver_t;

   // permission mask set travelling together
   typedef struct packed {
      logic [31:0] unassigned_bits_pattern;
      logic [31:0] unprivileged_writable_bits;
      logic [31:0] supervisor_writable_bits;
      logic [31:0] exec_isa_bits;
   } perm_masks_t;

   // register file write request
   typedef struct packed {
      logic valid;
      logic [3:0] index;
      logic [31:0] data;
   } gpr_write_t;

   // condition decode flags
   typedef struct packed {
      logic n;
      logic z;
      logic c;
      logic v;
   } flags_t;

endpackage : status_xfer_pkg

/* hdl/cond_check.sv */
// condition field evaluation against the current flags
module cond_check
   import status_xfer_pkg::*;
(
   input wire logic [3:0] cond_in,
   input wire flags_t flags_in,
   output logic pass_out
);

   // ----------------------------------------------------------------
   // base condition then optional inversion by the low bit
   // ----------------------------------------------------------------
   logic base;
   always_comb
   begin
      unique case (cond_in[3:1])
         3'h0: base = flags_in.z;
         3'h1: base = flags_in.c;
         3'h2: base = flags_in.n;
         3'h3: base = flags_in.v;
         3'h4: base = flags_in.c & ~flags_in.z;
         3'h5: base = (flags_in.n == flags_in.v);
         3'h6: base = ~flags_in.z & (flags_in.n == flags_in.v);
         3'h7: base = 1'b1;
      endcase
   end

   // 1111 is treated as not executed for these instructions
   assign pass_out = (cond_in == 4'hf) ? 1'b0 : (base ^ (cond_in[0] & (cond_in[3:1] != 3'h7)));

endmodule // cond_check

/* sim/gpr_file_model.sv */
// register file and operand supply facing the transfer unit
module gpr_file_model
   import status_xfer_pkg::*;
(
   input wire logic clk_in,
   input wire logic instr_valid_in,
   input wire logic [31:0] instr_in,
   input wire gpr_write_t gpr_write_in,
   output logic [31:0] source_gpr_out
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [31:0] regs [16];

   // --------------------------------------------------------
   // register contents
   // --------------------------------------------------------
   // clear all registers at time zero
   initial
   begin
      for (int i = 0; i < 16; i++)
         regs[i] = 32'h0;
   end

   // source register in the same cycle; scrambled when no instruction
   assign source_gpr_out = instr_valid_in ? regs[instr_in[SRC_HI:SRC_LO]] : ~regs[instr_in[SRC_HI:SRC_LO]];

   // destination register takes the status read result
   always @(posedge clk_in)
   begin
      if (gpr_write_in.valid === 1'b1)
         regs[gpr_write_in.index] <= gpr_write_in.data;
   end
endmodule // gpr_file_model

/* sim/status_word_transfer_tb.sv */
// self-checking bench for the status word transfer unit
module status_word_transfer_tb
   import status_xfer_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk_in, reset_in, instr_valid_in, unp;
   logic [31:0] instr_in, source_gpr_in, cur, sav;
   arch_ver_t arch_ver_in;
   gpr_write_t gpr_write_out;
   logic [3:0] src_idx;
   int miscompares = 0;
   int checks_done = 0;
   int rots [7] = '{0, 1, 2, 4, 8, 12, 15};

   // --------------------------------------------------------
   // design and partner
   // --------------------------------------------------------
   status_word_transfer DUT (.clk_in(clk_in), .reset_in(reset_in), .instr_valid_in(instr_valid_in),
      .instr_in(instr_in), .source_gpr_in(source_gpr_in), .arch_ver_in(arch_ver_in),
      .source_index_out(src_idx), .gpr_write_out(gpr_write_out), .current_status_word_out(cur),
      .saved_status_word_out(sav), .unpredictable_out(unp));
   gpr_file_model gprs (.clk_in(clk_in), .instr_valid_in(instr_valid_in), .instr_in(instr_in),
      .gpr_write_in(gpr_write_out), .source_gpr_out(source_gpr_in));

   // --------------------------------------------------------
   // shared tasks
   // --------------------------------------------------------
   // compare one value and count it
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks_done++;
      if (got !== exp)
      begin
         miscompares++;
         $display("BAD at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // drive one cycle of the instruction stream at the falling edge
   task automatic step(input logic v, input logic [31:0] i);
      @(negedge clk_in);
      instr_valid_in = v;
      instr_in = i;
   endtask

   // run one instruction, then judge status words, pulse flags
   task automatic exec_chk(input logic [31:0] i, input logic [31:0] c, input logic [31:0] s, input logic u,
      input logic w);
      step(1'b1, i);
      step(1'b0, 32'h0);
      chk(cur, c, "current word");
      chk(sav, s, "saved word");
      chk(32'(unp), 32'(u), "unpredictable");
      chk(32'(gpr_write_out.valid), 32'(w), "gpr write");
      chk(32'(src_idx), 32'(i[3:0]), "source index");
   endtask

   // --------------------------------------------------------
   // scenarios
   // --------------------------------------------------------
   // read both words into registers
   task automatic t_read;
      exec_chk(32'he10f5000, 32'h000000d3, 32'h0, 1'b0, 1'b1);
      chk(32'(gpr_write_out.index), 32'h5, "dest index");
      chk(gpr_write_out.data, 32'h000000d3, "read current");
      exec_chk(32'he14f6000, 32'h000000d3, 32'h0, 1'b0, 1'b1);
      chk(gpr_write_out.data, 32'h0, "read saved");
   endtask

   // flags write, then a conditional read right behind it
   task automatic t_cond;
      step(1'b1, 32'he328f4f0);
      step(1'b1, 32'h010f7000);
      chk(cur, 32'hf00000d3, "flags lane");
      step(1'b0, 32'h0);
      chk(32'(gpr_write_out.valid), 32'h1, "eq passes");
      chk(gpr_write_out.data, 32'hf00000d3, "eq read");
      exec_chk(32'h110f7000, 32'hf00000d3, 32'h0, 1'b0, 1'b0);
      exec_chk(32'hf10f7000, 32'hf00000d3, 32'h0, 1'b0, 1'b0);
   endtask

   // read-modify-write through the register file, then lane selection
   task automatic t_lanes;
      exec_chk(32'he10f3000, 32'hf00000d3, 32'h0, 1'b0, 1'b1);
      exec_chk(32'he12ff003, 32'hf00000d3, 32'h0, 1'b0, 1'b0);
      gprs.regs[1] = 32'h400f02d3;
      exec_chk(32'he129f001, 32'h400000d3, 32'h0, 1'b0, 1'b0);
      exec_chk(32'he12ff001, 32'h400f02d3, 32'h0, 1'b0, 1'b0);
   endtask

   // seven of the sixteen rotate amounts each land a single bit in the saved word
   task automatic t_rot;
      exec_chk(32'he168f001, 32'h400f02d3, 32'h40000000, 1'b0, 1'b0);
      for (int k = 0; k < 7; k++)
         exec_chk(32'he36ff001 | (rots[k] << 8), 32'h400f02d3, 32'h1 << ((32 - 2 * rots[k]) % 32), 1'b0,
            1'b0);
   endtask

   // refused operands leave both words alone; system mode round trip
   task automatic t_unp;
      exec_chk(32'he328f404, 32'h400f02d3, 32'h4, 1'b1, 1'b0);
      exec_chk(32'he12ff011, 32'h400f02d3, 32'h4, 1'b1, 1'b0);
      exec_chk(32'he3210020, 32'h400f02d3, 32'h4, 1'b1, 1'b0);
      exec_chk(32'he321f01f, 32'h400f021f, 32'h4, 1'b0, 1'b0);
      exec_chk(32'he14f6000, 32'h400f021f, 32'h4, 1'b1, 1'b0);
      exec_chk(32'he321f0d3, 32'h400f02d3, 32'h4, 1'b0, 1'b0);
   endtask

   // fifth version masks, ending in user mode
   task automatic t_dsp;
      arch_ver_in = VER_DSP5;
      gprs.regs[2] = 32'h000f0000;
      exec_chk(32'he12ff002, 32'h400f02d3, 32'h4, 1'b1, 1'b0);
      gprs.regs[2] = 32'h08000010;
      exec_chk(32'he12ff002, 32'h080f02d0, 32'h4, 1'b0, 1'b0);
   endtask

   // user mode limits and saved word access
   task automatic t_user;
      arch_ver_in = VER_NEWEST;
      gprs.regs[2] = 32'ha00002cf;
      exec_chk(32'he12ff002, 32'ha00002d0, 32'h4, 1'b0, 1'b0);
      exec_chk(32'he14f6000, 32'ha00002d0, 32'h4, 1'b1, 1'b0);
      exec_chk(32'he36ff0ff, 32'ha00002d0, 32'h4, 1'b1, 1'b0);
   endtask

   // --------------------------------------------------------
   // run control
   // --------------------------------------------------------
   // print the counts and the verdict
   task automatic end_of_test;
      $display("checks_done %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // 125 MHz clock
   initial
   begin
      clk_in = 1'b0;
      forever #4 clk_in = ~clk_in;
   end

   // hang guard
   initial
   begin
      repeat (5000) @(posedge clk_in);
      miscompares++;
      $display("BAD at %0t: run did not finish", $time);
      end_of_test();
   end

   // main sequence, with a second reset at the end
   initial
   begin
      reset_in = 1'b1;
      instr_valid_in = 1'b0;
      instr_in = 32'h0;
      arch_ver_in = VER_NEWEST;
      repeat (20) @(negedge clk_in);
      reset_in = 1'b0;
      chk(cur, 32'h000000d3, "reset current");
      t_read();
      t_cond();
      t_lanes();
      t_rot();
      t_unp();
      t_dsp();
      t_user();
      @(negedge clk_in);
      reset_in = 1'b1;
      repeat (2) @(negedge clk_in);
      reset_in = 1'b0;
      chk(cur, 32'h000000d3, "second reset current");
      chk(sav, 32'h0, "second reset saved");
      end_of_test();
   end
endmodule // status_word_transfer_tb
